// [hdl/ulbc_top.sv]
// serial port line, divisor and control registers with its bit engine
// assumes a wishbone master on clock and a serial line synchronous to it
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
module ulbc_top import ulbc_pkg::*; #(
    parameter int DEPTH = 16
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin
);
    localparam int PW = $clog2(DEPTH);

    // -------------------------------------------------------------
    // functions
    // -------------------------------------------------------------
    // parity of the active data bits, odd result when ones are odd
    function automatic logic par_of(input logic [7:0] d,
                                    input logic [1:0] wl);
        logic [7:0] m;
        m = 8'hFF >> (3'h3 - {1'b0, wl});
        return ^(d & m);
    endfunction : par_of

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    logic [15:0] divisor_whole_part_q;
    logic [5:0]  divisor_fraction_part_q;
    logic [7:0]  lcrh_q;
    logic [9:0]  ctl_q;
    logic [15:0] act_int_q;
    logic [5:0]  act_frac_q;
    logic        div_pend_q;

    logic acc_cyc, bus_wr, bus_rd, sel0;
    assign acc_cyc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr  = acc_cyc & wb_we_i;
    assign bus_rd  = acc_cyc & ~wb_we_i;
    assign sel0    = wb_sel_i[0];

    logic hit_data, hit_flags, hit_ibrd, hit_fbrd, hit_lcrh, hit_ctl;
    assign hit_data  = (wb_adr_i == OFS_DATA);
    assign hit_flags = (wb_adr_i == OFS_FLAGS);
    assign hit_ibrd  = (wb_adr_i == OFS_IBRD);
    assign hit_fbrd  = (wb_adr_i == OFS_FBRD);
    assign hit_lcrh  = (wb_adr_i == OFS_LCRH);
    assign hit_ctl   = (wb_adr_i == OFS_CTL);

    // decoded control fields
    logic send_break, parity_enable, even_parity_select, double_stop_select, queue_enable, fixed_parity_select, p_en, tx_en, rx_en;
    logic [1:0] word_length_field;
    assign send_break  = lcrh_q[LC_BRK];
    assign parity_enable  = lcrh_q[LC_PEN];
    assign even_parity_select  = lcrh_q[LC_EPS];
    assign double_stop_select = lcrh_q[LC_DOUBLE_STOP_SELECT];
    assign queue_enable  = lcrh_q[LC_FEN];
    assign fixed_parity_select  = lcrh_q[LC_SPS];
    assign word_length_field = lcrh_q[LC_WORD_LENGTH_FIELD_LO +: 2];
    assign p_en  = ctl_q[CT_EN];
    assign tx_en = ctl_q[CT_TXE];
    assign rx_en = ctl_q[CT_RXE];

    // -------------------------------------------------------------
    // queues, one entry deep when queueing is off
    // -------------------------------------------------------------
    logic [7:0]  tq_q [DEPTH];
    logic [7:0]  rq_q [DEPTH];
    logic [PW-1:0] tw_q, tr_q, rw_q, rr_q;
    logic [PW:0] tcnt_q, rcnt_q;
    logic [PW:0] cap;
    logic tx_full, tx_empty, rx_full, rx_empty;
    logic tx_push, tx_pop, rx_push, rx_pop, rx_done;
    logic [7:0] rx_word;
    assign cap      = queue_enable ? (PW+1)'(DEPTH) : (PW+1)'(1);
    assign tx_full  = (tcnt_q >= cap);
    assign rx_full  = (rcnt_q >= cap);
    assign tx_empty = (tcnt_q == '0);
    assign rx_empty = (rcnt_q == '0);
    // writes into a full queue are dropped, a full receive queue drops
    assign tx_push  = bus_wr & hit_data & sel0 & ~tx_full;
    assign rx_pop   = bus_rd & hit_data & ~rx_empty;
    assign rx_push  = rx_done & ~rx_full;

    // storage and pointers
    always_ff @(posedge clock) begin
        if (tx_push) tq_q[tw_q] <= wb_dat_i[7:0];
        if (rx_push) rq_q[rw_q] <= rx_word;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            tw_q <= '0;
            tr_q <= '0;
            rw_q <= '0;
            rr_q <= '0;
            tcnt_q <= '0;
            rcnt_q <= '0;
        end else begin
            if (tx_push) tw_q <= ptr_inc(tw_q);
            if (tx_pop)  tr_q <= ptr_inc(tr_q);
            if (rx_push) rw_q <= ptr_inc(rw_q);
            if (rx_pop)  rr_q <= ptr_inc(rr_q);
            tcnt_q <= tcnt_q + (PW+1)'(tx_push) - (PW+1)'(tx_pop);
            rcnt_q <= rcnt_q + (PW+1)'(rx_push) - (PW+1)'(rx_pop);
        end
    end

    // -------------------------------------------------------------
    // bit-rate tick: whole plus fraction/64 clocks per tick, one clock per tick when whole is zero
    // -------------------------------------------------------------
    logic [16:0] bcnt_q, blim;
    logic [5:0]  bacc_q;
    logic        bext_q, tick_q;
    logic [6:0]  bsum;
    assign blim = (act_int_q == '0) ? 17'h00001
                : {1'b0, act_int_q} + 17'(bext_q);
    assign bsum = {1'b0, bacc_q} + {1'b0, act_frac_q};

    always_ff @(posedge clock) begin
        if (!rstn) begin
            bcnt_q <= 17'h00001;
            bacc_q <= '0;
            bext_q <= 1'b0;
            tick_q <= 1'b0;
        end else if (bcnt_q >= blim) begin
            bcnt_q <= 17'h00001;
            tick_q <= 1'b1;
            bacc_q <= bsum[5:0];
            bext_q <= bsum[6] & (act_int_q != '0);
        end else begin
            bcnt_q <= bcnt_q + 17'h00001;
            tick_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // transmitter
    // -------------------------------------------------------------
    ulbc_state_t ts_q;
    logic [3:0]  tsub_q;
    logic [2:0]  tbit_q;
    logic [7:0]  tsh_q;
    logic        tstop_q, tout_q;
    logic        t_go, t_bit_end, t_last, tpar;
    assign t_go      = p_en & tx_en & ~tx_empty;
    assign tx_pop    = (ts_q == ULBC_IDLE) & t_go;
    assign t_bit_end = tick_q & (tsub_q == OVS_LAST);
    assign t_last    = (tbit_q == 3'(word_length_field) + WORD_LENGTH_FIELD_MIN);
    // sticky parity is 0 with even select, else 1
    assign tpar = fixed_parity_select ? ~even_parity_select
                : (par_of(tsh_q, word_length_field) ^ ~even_parity_select);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ts_q    <= ULBC_IDLE;
            tsub_q  <= '0;
            tbit_q  <= '0;
            tsh_q   <= '0;
            tstop_q <= 1'b0;
            tout_q  <= 1'b1;
        end else begin
            if (tick_q) tsub_q <= tsub_q + 4'h1;
            case (ts_q)
                ULBC_IDLE: begin
                    tout_q <= ~send_break;
                    if (tx_pop) begin
                        ts_q   <= ULBC_START;
                        tsh_q  <= tq_q[tr_q];
                        tsub_q <= '0;
                        tout_q <= 1'b0;
                    end
                end
                ULBC_START: if (t_bit_end) begin
                    ts_q   <= ULBC_DATA;
                    tbit_q <= '0;
                    tout_q <= tsh_q[0];
                end
                ULBC_DATA: if (t_bit_end) begin
                    if (t_last) begin
                        ts_q    <= parity_enable ? ULBC_PAR : ULBC_STOP;
                        tout_q  <= parity_enable ? tpar : 1'b1;
                        tstop_q <= double_stop_select;
                    end else begin
                        tbit_q <= tbit_q + 3'h1;
                        tout_q <= tsh_q[tbit_q + 3'h1];
                    end
                end
                ULBC_PAR: if (t_bit_end) begin
                    ts_q   <= ULBC_STOP;
                    tout_q <= 1'b1;
                end
                ULBC_STOP: if (t_bit_end) begin
                    // second stop bit only when double stop chosen
                    if (tstop_q) tstop_q <= 1'b0;
                    else ts_q <= ULBC_IDLE;
                end
                default: ts_q <= ULBC_IDLE;
            endcase
        end
    end
    assign serial_out_pin = tout_q;

    // busy while anything queued or a character still shifting
    logic busy;
    assign busy = ~tx_empty | (ts_q != ULBC_IDLE);

    // -------------------------------------------------------------
    // receiver, one stop bit checked whatever the stop setting
    // -------------------------------------------------------------
    ulbc_state_t rs_q;
    logic [3:0]  rsub_q;
    logic [2:0]  rbit_q;
    logic [7:0]  rsh_q;
    logic        rpar_ok_q, rdone_q;
    logic        r_bit_end, r_last, rpar_exp;
    assign r_bit_end = tick_q & (rsub_q == OVS_LAST);
    assign r_last    = (rbit_q == 3'(word_length_field) + WORD_LENGTH_FIELD_MIN);
    assign rpar_exp  = fixed_parity_select ? ~even_parity_select
                     : (par_of(rsh_q, word_length_field) ^ ~even_parity_select);
    assign rx_done   = rdone_q;
    assign rx_word   = rsh_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rs_q      <= ULBC_IDLE;
            rsub_q    <= '0;
            rbit_q    <= '0;
            rsh_q     <= '0;
            rpar_ok_q <= 1'b1;
            rdone_q   <= 1'b0;
        end else begin
            rdone_q <= 1'b0;
            if (tick_q) rsub_q <= rsub_q + 4'h1;
            case (rs_q)
                ULBC_IDLE: begin
                    if (tick_q & p_en & rx_en & ~serial_in_pin) begin
                        rs_q   <= ULBC_START;
                        rsub_q <= '0;
                    end
                end
                ULBC_START: if (tick_q & (rsub_q == OVS_MID)) begin
                    // a glitch shorter than half a bit is ignored
                    rs_q   <= serial_in_pin ? ULBC_IDLE : ULBC_DATA;
                    rsub_q <= '0;
                    rbit_q <= '0;
                    rsh_q  <= '0;
                end
                ULBC_DATA: if (r_bit_end) begin
                    rsh_q[rbit_q] <= serial_in_pin;
                    if (r_last) begin
                        rs_q <= parity_enable ? ULBC_PAR : ULBC_STOP;
                        rpar_ok_q <= 1'b1;
                    end else begin
                        rbit_q <= rbit_q + 3'h1;
                    end
                end
                ULBC_PAR: if (r_bit_end) begin
                    rpar_ok_q <= (serial_in_pin == rpar_exp);
                    rs_q      <= ULBC_STOP;
                end
                ULBC_STOP: if (r_bit_end) begin
                    // framing and parity faults drop the character
                    rdone_q <= serial_in_pin & rpar_ok_q;
                    rs_q    <= ULBC_IDLE;
                end
                default: rs_q <= ULBC_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------
    // configuration registers and divisor hand-over
    // -------------------------------------------------------------
    logic both_idle;
    assign both_idle = (ts_q == ULBC_IDLE) & (rs_q == ULBC_IDLE);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            divisor_whole_part_q    <= IBRD_RST;
            divisor_fraction_part_q <= FBRD_RST;
            lcrh_q     <= LCRH_RST;
            ctl_q      <= CTL_RST;
            act_int_q  <= IBRD_RST;
            act_frac_q <= FBRD_RST;
            div_pend_q <= 1'b0;
        end else begin
            if (bus_wr & hit_ibrd) begin
                if (sel0) divisor_whole_part_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    divisor_whole_part_q[15:8] <= wb_dat_i[15:8];
            end
            if (bus_wr & hit_fbrd & sel0)
                divisor_fraction_part_q <= wb_dat_i[5:0];
            if (bus_wr & hit_lcrh & sel0) begin
                lcrh_q     <= wb_dat_i[7:0];
                div_pend_q <= 1'b1;
            end else if (div_pend_q & both_idle) begin
                // frames in flight keep their timing
                act_int_q  <= divisor_whole_part_q;
                act_frac_q <= divisor_fraction_part_q;
                div_pend_q <= 1'b0;
            end
            if (bus_wr & hit_ctl) begin
                if (sel0) ctl_q[CT_EN] <= wb_dat_i[CT_EN];
                if (wb_sel_i[1])
                    ctl_q[CT_RXE:CT_TXE] <= wb_dat_i[CT_RXE:CT_TXE];
            end
        end
    end

    // -------------------------------------------------------------
    // read mux and acknowledge
    // -------------------------------------------------------------
    logic [31:0] flags_w, rd_w;
    always_comb begin
        flags_w = '0;
        flags_w[FLG_BUSY] = busy;
        flags_w[FLG_RX_QUEUE_EMPTY_FLAG] = rx_empty;
        flags_w[FLG_TXFF] = tx_full;
        flags_w[FLG_RXFF] = rx_full;
        flags_w[FLG_TXFE] = tx_empty;
    end
    assign rd_w = hit_data  ? {24'h000000, rq_q[rr_q]}
                : hit_flags ? flags_w
                : hit_ibrd  ? {16'h0000, divisor_whole_part_q}
                : hit_fbrd  ? {26'h0000000, divisor_fraction_part_q}
                : hit_lcrh  ? {24'h000000, lcrh_q}
                : hit_ctl   ? {22'h000000, ctl_q}
                : 32'h00000000;

    // one wait state; unmapped addresses ack with zero data
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= acc_cyc;
            wb_dat_o <= bus_rd ? rd_w : 32'h00000000;
        end
    end
endmodule : ulbc_top

// [common/ulbc_pkg.sv]
// package of offsets, field positions, reset values and timing counts
// assumes a 32-bit classic wishbone slave at word-aligned byte offsets
// Operation
// - receive-empty flag bit 4 reflects queue state
// - busy holds until last stop bit shifted
// - busy rises when transmit queue turns non-empty
// - zero whole divisor means ratio one
// - new divisor waits for current character
// - divisors applied on line control write
// - whole divisor 16 bits, resets zero
// - fraction divisor 6 bits, resets zero
// - fixed parity sends 0 or 1
// - word length 5 to 8, reset five
// - queue enable selects queue or single holder
// - two stop bits sent, one checked
// - even select picks even or odd parity
// - parity enable adds parity bit
// - break drives output low after character
// - control resets clear except transmit and receive enables set
// - port works only while port enabled
// - disabling finishes current character first
// - enable bits at 0, 8, 9
package ulbc_pkg;
    // -------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------
    localparam logic [7:0] OFS_DATA  = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h18;
    localparam logic [7:0] OFS_IBRD  = 8'h24;
    localparam logic [7:0] OFS_FBRD  = 8'h28;
    localparam logic [7:0] OFS_LCRH  = 8'h2C;
    localparam logic [7:0] OFS_CTL   = 8'h30;
    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int FLG_BUSY   = 3;
    localparam int FLG_RX_QUEUE_EMPTY_FLAG   = 4;
    localparam int FLG_TXFF   = 5;
    localparam int FLG_RXFF   = 6;
    localparam int FLG_TXFE   = 7;
    localparam int LC_BRK     = 0;
    localparam int LC_PEN     = 1;
    localparam int LC_EPS     = 2;
    localparam int LC_DOUBLE_STOP_SELECT    = 3;
    localparam int LC_FEN     = 4;
    localparam int LC_WORD_LENGTH_FIELD_LO = 5;
    localparam int LC_SPS     = 7;
    localparam int CT_EN      = 0;
    localparam int CT_TXE     = 8;
    localparam int CT_RXE     = 9;
    // -------------------------------------------------------------
    // reset values and timing counts
    // -------------------------------------------------------------
    localparam logic [15:0] IBRD_RST = 16'h0000;
    localparam logic [5:0]  FBRD_RST = 6'h00;
    localparam logic [7:0]  LCRH_RST = 8'h00;
    localparam logic [9:0]  CTL_RST  = 10'h300;
    localparam logic [3:0]  OVS_LAST = 4'hF;   // 16 ticks per bit
    localparam logic [3:0]  OVS_MID  = 4'h7;   // start bit centre
    localparam logic [2:0]  WORD_LENGTH_FIELD_MIN = 3'h4;   // word_length_field 0 gives 5 bits
    typedef enum logic [2:0] {
        ULBC_IDLE, ULBC_START, ULBC_DATA, ULBC_PAR, ULBC_STOP
    } ulbc_state_t;
endpackage : ulbc_pkg

// [dv/ulbc_monitor.sv]
// checker: bus answers, read masks and busy flag of ulbc_top
// assumes a master that holds each request until it samples ack
`timescale 1ns/1ps
module ulbc_monitor import ulbc_pkg::*; (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        serial_in_pin,
    input wire logic        serial_out_pin
);
    // ------------------------------
    // bus and register properties
    // ------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // read answer, decoded from the address the master still holds
    wire rd_ack = wb_ack_o && !wb_we_i;
    sequence data_wr_s;
        wb_ack_o && wb_we_i && wb_adr_i == OFS_DATA && wb_sel_i[0];
    endsequence
    sequence flag_rd_s;
        rd_ack && wb_adr_i == OFS_FLAGS;
    endsequence
    ack_next_cycle_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    data_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside the ack cycle");
    flag_reserved_a: assert property (
        flag_rd_s |-> wb_dat_o[31:8] == 24'h0 && wb_dat_o[2:0] == 3'h0)
        else $error("flag reserved bits set");
    whole_reserved_a: assert property (
        rd_ack && wb_adr_i == OFS_IBRD |-> wb_dat_o[31:16] == 16'h0)
        else $error("whole divisor reserved bits set");
    frac_reserved_a: assert property (
        rd_ack && wb_adr_i == OFS_FBRD |-> wb_dat_o[31:6] == 26'h0)
        else $error("fraction divisor reserved bits set");
    ctl_reserved_a: assert property (
        rd_ack && wb_adr_i == OFS_CTL |-> wb_dat_o[31:10] == 22'h0)
        else $error("control reserved bits set");
    busy_on_write_a: assert property (
        data_wr_s ##1 !wb_ack_o ##[1:3] flag_rd_s |-> wb_dat_o[FLG_BUSY])
        else $error("busy clear just after a data write");
endmodule : ulbc_monitor

bind ulbc_top ulbc_monitor u_monitor (
    .clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin)
);

// [dv/ulbc_partner.sv]
// remote serial device: sends frames and captures the output line
// assumes lines synchronous to clock and a bit period set by the bench
`timescale 1ns/1ps
module ulbc_partner (
    input  wire logic       clock,
    input  wire logic       serial_out_pin,
    output logic            serial_in_pin,
    input  wire logic [7:0] bit_clks,
    input  wire logic [3:0] frame_bits,
    input  wire logic       listen
);
    // ------------------------------
    // sender and listener
    // ------------------------------
    logic [11:0] got_q[$];
    logic [11:0] v;
    // marking level between our frames
    initial serial_in_pin = 1'b1;
    // start bit, then n bits lsb first, then back to marking
    task automatic send_frame(input logic [11:0] f, input int n);
        @(posedge clock);
        serial_in_pin <= 1'b0;
        repeat (bit_clks) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            serial_in_pin <= f[i];
            repeat (bit_clks) @(posedge clock);
        end
        serial_in_pin <= 1'b1;
    endtask : send_frame
    // mid-bit sampling; a break would look like endless frames, so the
    // bench turns listening off around it
    initial forever begin
        @(posedge clock);
        if (listen && serial_out_pin === 1'b0) begin
            v = '0;
            repeat (bit_clks / 2) @(posedge clock);
            for (int i = 0; i < frame_bits; i++) begin
                repeat (bit_clks) @(posedge clock);
                v[i] = serial_out_pin;
            end
            got_q.push_back(v);
        end
    end
endmodule : ulbc_partner

// [dv/ulbc_top_tb.sv]
// bench for ulbc_top: registers, frame formats, receive, divisors,
// break and disable; assumes ulbc_partner on the serial lines
`timescale 1ns/1ps
module ulbc_top_tb import ulbc_pkg::*;;
    // ------------------------------
    // signals, tables and model state
    // ------------------------------
    logic        clock, rstn, cyc, stb, we, ack, sin, sout, listen;
    logic [7:0]  adr, bitc, lc, d;
    logic [3:0]  sel, nfb;
    logic [31:0] wdat, rdat, q, r, v32;
    logic [11:0] exp_q[$];
    int          errors, tests_run, cycles, lo;
    int          seed = 32'hFFB51B3F;
    logic [7:0]  ra[5] = '{OFS_IBRD, OFS_FBRD, OFS_LCRH, 8'h40, OFS_CTL};
    logic [31:0] rm[5] = '{32'hFFFF, 32'h3F, 32'hFF, 32'h0, 32'h301};
    logic [15:0] cw[5] = '{16'h0, 16'h2, 16'h1, 16'h2, 16'h1};
    logic [5:0]  cf[5] = '{6'h20, 6'h0, 6'h20, 6'h0, 6'h0};
    logic [7:0]  cl[5] = '{8'h60, 8'h16, 8'h2A, 8'hC6, 8'hF2};
    ulbc_top #(.DEPTH(2)) dut (
        .clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .serial_in_pin(sin),
        .serial_out_pin(sout));
    ulbc_partner peer (
        .clock(clock), .serial_out_pin(sout), .serial_in_pin(sin),
        .bit_clks(bitc), .frame_bits(nfb), .listen(listen));
    // clock, and a hang guard well above the whole run
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("counts: %0d compared, %0d mismatched", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out
    task automatic fail(input string m);
        errors++;
        $display("unexpected at %0t: %s", $time, m);
    endtask : fail
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) fail($sformatf("read %h, model %h", g, e));
    endtask : chk_reg
    task automatic chk_frame(input logic [11:0] g, input logic [11:0] e);
        tests_run++;
        if (g !== e) fail($sformatf("frame %h, model %h", g, e));
    endtask : chk_frame
    // one classic cycle; upper byte lanes are random, they are unused
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] v);
        int n;
        n = 0;
        r = $random(seed);
        @(posedge clock);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= v;
        sel  <= {r[1:0], 2'b11};
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) fail("bus not answered");
    endtask : wb
    // model frame: data lsb first, parity, stop bits; unused bits zero
    function automatic logic [11:0] frame(input logic [7:0] v,
                                          input logic [7:0] f);
        logic [11:0] b;
        logic [7:0]  m;
        int          n;
        m = 8'hFF >> (2'h3 - f[6:5]);
        n = 5 + f[6:5];
        b = {4'h0, v & m};
        if (f[1]) begin
            b[n] = f[7] ? ~f[2] : (f[2] ? ^(v & m) : ~^(v & m));
            n++;
        end
        b[n] = 1'b1;
        b[n + 1] = f[3];
        return b;
    endfunction : frame
    // port off first, divisors, then line control to apply them
    task automatic set_cfg(input logic [15:0] w, input logic [5:0] f,
                           input logic [7:0] c);
        wb(1'b1, OFS_CTL, 32'h300);
        wb(1'b1, OFS_IBRD, {16'h0, w});
        wb(1'b1, OFS_FBRD, {26'h0, f});
        wb(1'b1, OFS_LCRH, {24'h0, c});
        wb(1'b1, OFS_CTL, 32'h301);
        lc = c;
        bitc <= 8'(w == 0 ? 16 : 16 * w + f / 4);
        nfb  <= 4'(6 + c[6:5] + c[1] + c[3]);
    endtask : set_cfg
    task automatic tx_start(input logic [7:0] v);
        exp_q.push_back(frame(v, lc));
        wb(1'b1, OFS_DATA, {r[23:0], v});
    endtask : tx_start
    task automatic tx_check();
        int n;
        n = 0;
        while (peer.got_q.size() == 0 && n < 3000) begin
            @(posedge clock);
            n++;
        end
        if (n == 3000) fail("no frame on the line");
        else chk_frame(peer.got_q.pop_front(), exp_q.pop_front());
    endtask : tx_check
    task automatic flags(input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, OFS_FLAGS, 32'h0);
        chk_reg(q & m, e);
    endtask : flags
    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        {rstn, cyc, stb, we, listen} = 5'h0;
        {adr, sel, wdat, lc, r} = '0;
        bitc = 8'h10;
        nfb = 4'hA;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, ra[i], 32'h0);
            chk_reg(q, i == 4 ? 32'h300 : 32'h0);
        end
        flags(32'hFFFFFFFF, 32'h90);
        for (int i = 0; i < 15; i++) begin
            v32 = $random(seed);
            wb(1'b1, ra[i / 3], v32);
            wb(1'b0, ra[i / 3], 32'h0);
            chk_reg(q, v32 & rm[i / 3]);
        end
        // a random break left in line control would pose as a frame
        wb(1'b1, OFS_LCRH, 32'h0);
        $display("test registers done");
        listen <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            set_cfg(cw[k], cf[k], cl[k]);
            d = 8'($random(seed));
            tx_start(d);
            flags(32'h8, 32'h8);
            tx_check();
            flags(32'h8, 32'h8);
            repeat (bitc) @(posedge clock);
            flags(32'h18, 32'h10);
            peer.send_frame(frame(d, lc), nfb);
            flags(32'h10, 32'h0);
            wb(1'b0, OFS_DATA, 32'h0);
            chk_reg(q, {24'h0, d & (8'hFF >> (2'h3 - lc[6:5]))});
            flags(32'h10, 32'h10);
            if (lc[1]) begin
                peer.send_frame(frame(d, lc) ^ (12'h1 << (5 + lc[6:5])), nfb);
                flags(32'h10, 32'h10);
            end
            $display("test format %0d done", k);
        end
        set_cfg(16'h2, 6'h0, 8'h70);
        tx_start(8'hA5);
        tx_start(8'h3C);
        wb(1'b1, OFS_IBRD, 32'h3);
        tx_check();
        tx_check();
        // line idle first, so the next character is in flight at the write
        repeat (bitc) @(posedge clock);
        tx_start(8'h81);
        wb(1'b1, OFS_LCRH, 32'h70);
        tx_check();
        repeat (bitc) @(posedge clock);
        bitc <= 8'h30;
        tx_start(8'h5A);
        tx_check();
        $display("test divisor update done");
        set_cfg(16'h0, 6'h0, 8'h60);
        tx_start(8'hC3);
        wb(1'b1, OFS_LCRH, 32'h61);
        tx_check();
        listen <= 1'b0;
        repeat (bitc) @(posedge clock);
        lo = 0;
        // break held two ten-bit frames, as software must
        repeat (20 * bitc) begin
            @(posedge clock);
            lo += (sout === 1'b0);
        end
        chk_reg(32'(lo), 32'(20 * bitc));
        wb(1'b1, OFS_LCRH, 32'h60);
        repeat (2) @(posedge clock);
        chk_reg({31'h0, sout}, 32'h1);
        listen <= 1'b1;
        $display("test break done");
        tx_start(8'h96);
        wb(1'b1, OFS_CTL, 32'h300);
        tx_check();
        tx_start(8'h69);
        lo = 0;
        repeat (24 * bitc) begin
            @(posedge clock);
            lo += (sout === 1'b0);
        end
        chk_reg(32'(lo), 32'h0);
        flags(32'hA8, 32'h28);
        wb(1'b1, OFS_CTL, 32'h301);
        tx_check();
        $display("test disable done");
        close_out();
    end
endmodule : ulbc_top_tb
